// >>> verilog/bio_pkg.sv
package bio_pkg;

  // ************************************************
  // Widths
  // ************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int LADDR_W = 11;
  localparam int PNUM_W = 6;

  // ************************************************
  // Window offsets and bank codes
  // ************************************************
  localparam logic [3:0] OFF_TX_CTRL = 4'h0;
  localparam logic [3:0] OFF_BANK_SEL = 4'he;
  localparam logic [3:0] OFF_CFG = 4'h0;
  localparam logic [2:0] BANK_TX = 3'h0;
  localparam logic [2:0] BANK_CFG = 3'h4;
  localparam logic [2:0] BANK_LAST = 3'h4;
  localparam logic [2:0] BANK_RST = 3'h0;
  localparam logic [7:0] SIG_BYTE = 8'h33;
  localparam logic [7:0] NONE_BYTE = 8'h33;

  // ************************************************
  // Transmit control fields
  // ************************************************
  localparam int TC_TXENA = 0;
  localparam int TC_LOOP = 1;
  localparam int TC_FORCOL = 2;
  localparam int TC_TXP_EN = 3;
  localparam int TC_PAD_EN = 7;
  localparam int TC_FCS_SUP = 8;
  localparam int TC_CAR_MON = 10;
  localparam int TC_FD_ACC = 11;
  localparam int TC_STP_SQE = 12;
  localparam int TC_PHY_LOOP = 13;
  localparam int TC_ET_TYPE = 14;
  localparam int TC_SW_FDX = 15;
  localparam logic [15:0] TX_CTRL_MASK = 16'hfd8f;
  localparam logic [15:0] TX_CTRL_RST = 16'h0000;

  // ************************************************
  // Configuration option and status fields
  // ************************************************
  localparam int CO_SRST = 7;
  localparam int CO_LEV_IRQ = 6;
  localparam int CO_WR_ATTR = 2;
  localparam int CO_FUNC_EN = 0;
  localparam int CS_IO8 = 5;
  localparam int CS_PWRDN = 2;
  localparam logic [7:0] CFG_OPT_MASK = 8'h85;
  localparam logic [7:0] CFG_OPT_RST = 8'h00;
  localparam logic [7:0] CFG_OPT_RO = 8'h40;
  localparam logic [7:0] CFG_STS_MASK = 8'h24;
  localparam logic [7:0] CFG_STS_RST = 8'h00;

endpackage : bio_pkg

// >>> verilog/bio_underrun_cmp.sv
`timescale 1ns/1ps
module bio_underrun_cmp
  import bio_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic early_tx_enable_i,
  input wire logic compare_type_i,
  input wire logic [LADDR_W-1:0] dma_tx_addr_i,
  input wire logic [LADDR_W-1:0] load_addr_i,
  input wire logic [PNUM_W-1:0] tx_pkt_num_i,
  input wire logic [PNUM_W-1:0] load_pkt_num_i,
  output logic force_underrun_o
);

  logic ahead;
  logic same_pkt;
  logic force_nxt;

  assign ahead = dma_tx_addr_i > load_addr_i;
  assign same_pkt = tx_pkt_num_i == load_pkt_num_i;
  // Type 1 only starves DMA when both sides work on one packet
  assign force_nxt = early_tx_enable_i & ahead & (~compare_type_i | same_pkt); // [RULE_16] [RULE_17]

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      force_underrun_o <= 1'b0;
    else
      force_underrun_o <= force_nxt;
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  a_addr_only_force: assert property (early_tx_enable_i && !compare_type_i && ahead // [RULE_16]
    |=> force_underrun_o)
    else $error("underrun not forced on address overtake");
  a_pkt_match_gate: assert property (compare_type_i && !same_pkt // [RULE_17]
    |=> !force_underrun_o)
    else $error("underrun forced for different packets");

endmodule : bio_underrun_cmp

// >>> verilog/bio_window_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Window decodes sixteen byte locations; register depends on selected bank.
// [RULE_02] Offset E reaches the bank selection register in every bank.
// [RULE_03] Bank codes 0 to 4 select banks; codes 5 to 7 select none.
// [RULE_04] Bank selection register stays readable and writable for any bank code.
// [RULE_05] Bank selection register is inaccessible during power down.
// [RULE_06] Nonexistent bank: writes dropped, byte reads return 33h.
// [RULE_07] Upper byte of bank selection always reads 33h.
// [RULE_08] All five banks reachable in both modes; bank 4 holds configuration.
// [RULE_09] Offset addresses even byte or word; odd byte at offset plus one.
// [RULE_10] Window works as an 8-bit or a 16-bit I/O space.
// [RULE_11] In 16-bit mode every register takes word and byte accesses.
// [RULE_12] Hard reset: bank field zero, transmit control bits zero.
// [RULE_13] Suppress bit set stops frame check append; clear appends it.
// [RULE_14] Switched full duplex: no deferral, no collision detection.
// [RULE_15] Switched full duplex forces duplex accept on, carrier monitor off.
// [RULE_16] Compare type 0: force underrun when DMA address passes load address.
// [RULE_17] Compare type 1: also require matching packet numbers.
// [RULE_18] PHY block loopback loops serial data, skipping the encoder, default off.
// [RULE_19] Host soft resets after leaving PHY block loopback.
// [RULE_20] Soft reset clears function registers and holds ready pin low.
// [RULE_21] Power down from power down bit, or function disabled in PCMCIA mode.
// [RULE_22] Undefined bits ignore writes and read zero.
module bio_window_top
  import bio_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] host_addr_i,
  input wire logic host_rd_i,
  input wire logic host_wr_i,
  input wire logic host_word_i,
  input wire logic [DATA_W-1:0] host_wdata_i,
  output logic [DATA_W-1:0] host_rdata_o,
  output logic host_rvalid_o,
  input wire logic host_bus16_i,
  input wire logic pcmcia_mode_i,
  input wire logic early_tx_enable_i,
  input wire logic [LADDR_W-1:0] dma_tx_addr_i,
  input wire logic [LADDR_W-1:0] load_addr_i,
  input wire logic [PNUM_W-1:0] tx_pkt_num_i,
  input wire logic [PNUM_W-1:0] load_pkt_num_i,
  output logic [2:0] bank_o,
  output logic io_16bit_o,
  output logic fcs_append_o,
  output logic csma_enable_o,
  output logic full_duplex_accept_o,
  output logic carrier_monitor_o,
  output logic phy_loopback_o,
  output logic encdec_loopback_o,
  output logic tx_enable_o,
  output logic pad_enable_o,
  output logic force_collision_o,
  output logic stop_on_sqe_o,
  output logic force_underrun_o,
  output logic power_down_o,
  output logic int_ready_o,
  output logic attr_write_en_o
);

  // ************************************************
  // State
  // ************************************************
  logic [2:0] bank_r;
  logic [2:0] bank_nxt;
  logic [15:0] tx_r;
  logic [15:0] tx_nxt;
  logic [7:0] cfg_opt_r;
  logic [7:0] cfg_opt_nxt;
  logic [7:0] cfg_sts_r;
  logic [7:0] cfg_sts_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;

  // ************************************************
  // Address decode
  // ************************************************
  logic [3:0] word_off;
  logic word_acc;
  logic hi_sel;
  logic bank_exists;
  logic hit_bsel;
  logic hit_tx;
  logic hit_cfg;
  logic pwr_down;
  logic blocked;
  logic wr_ok;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wd_lo;
  logic [7:0] wd_hi;
  logic soft_hold;
  logic srst_set;

  assign word_off = {host_addr_i[3:1], 1'b0}; // [RULE_01]
  // Narrow bus forces byte cycles even if a word is requested
  assign io_16bit_o = host_bus16_i & ~cfg_sts_r[CS_IO8]; // [RULE_10]
  assign word_acc = host_word_i & io_16bit_o; // [RULE_11]
  assign hi_sel = ~word_acc & host_addr_i[0]; // [RULE_09]
  assign bank_exists = bank_r <= BANK_LAST; // [RULE_03]
  assign hit_bsel = word_off == OFF_BANK_SEL; // [RULE_02] [RULE_04]
  assign hit_tx = (bank_r == BANK_TX) && (word_off == OFF_TX_CTRL);
  // Bank 4 decode does not look at the bus mode
  assign hit_cfg = (bank_r == BANK_CFG) && (word_off == OFF_CFG); // [RULE_08]

  assign pwr_down = cfg_sts_r[CS_PWRDN] | (pcmcia_mode_i & ~cfg_opt_r[CO_FUNC_EN]); // [RULE_21]
  // Configuration word stays open so power down can be undone
  assign blocked = pwr_down & ~hit_cfg; // [RULE_05]
  assign wr_ok = host_wr_i & ~blocked;
  assign wr_lo = wr_ok & (word_acc | ~host_addr_i[0]); // [RULE_09]
  assign wr_hi = wr_ok & (word_acc | host_addr_i[0]); // [RULE_09]
  assign wd_lo = host_wdata_i[7:0];
  assign wd_hi = word_acc ? host_wdata_i[15:8] : host_wdata_i[7:0];

  assign soft_hold = cfg_opt_r[CO_SRST];
  assign srst_set = hit_cfg & wr_lo & wd_lo[CO_SRST] & ~soft_hold;

  // ************************************************
  // Next values
  // ************************************************
  always_comb
  begin
    bank_nxt = bank_r;
    if (srst_set)
      bank_nxt = BANK_RST; // [RULE_20]
    else if (hit_bsel && wr_lo)
      bank_nxt = wd_lo[2:0]; // [RULE_04]
  end

  always_comb
  begin
    tx_nxt = tx_r;
    if (hit_tx && wr_lo)
      tx_nxt[7:0] = wd_lo & TX_CTRL_MASK[7:0]; // [RULE_22]
    if (hit_tx && wr_hi)
      tx_nxt[15:8] = wd_hi & TX_CTRL_MASK[15:8]; // [RULE_22]
    if (soft_hold || srst_set)
      tx_nxt = TX_CTRL_RST; // [RULE_20]
  end

  always_comb
  begin
    cfg_opt_nxt = cfg_opt_r;
    if (hit_cfg && wr_lo)
      cfg_opt_nxt = wd_lo & CFG_OPT_MASK; // [RULE_22]
  end

  always_comb
  begin
    cfg_sts_nxt = cfg_sts_r;
    if (hit_cfg && wr_hi)
      cfg_sts_nxt = wd_hi & CFG_STS_MASK; // [RULE_22]
    if (soft_hold || srst_set)
      cfg_sts_nxt = CFG_STS_RST; // [RULE_20]
  end

  // ************************************************
  // Read path
  // ************************************************
  logic [15:0] rd_word;
  logic [15:0] bsel_word;
  logic [15:0] cfg_word;
  logic [15:0] lane_word;

  assign bsel_word = {SIG_BYTE, 5'h00, bank_r}; // [RULE_07] [RULE_22]
  assign cfg_word = {cfg_sts_r, cfg_opt_r | CFG_OPT_RO};

  always_comb
  begin
    if (blocked)
      rd_word = 16'h0000; // [RULE_05]
    else if (hit_bsel)
      rd_word = bsel_word; // [RULE_02]
    else if (!bank_exists)
      rd_word = {NONE_BYTE, NONE_BYTE}; // [RULE_06]
    else if (hit_tx)
      rd_word = tx_r;
    else if (hit_cfg)
      rd_word = cfg_word; // [RULE_08]
    else
      rd_word = 16'h0000;
  end

  // Byte reads come back on the low lane
  assign lane_word = word_acc ? rd_word
                              : {8'h00, hi_sel ? rd_word[15:8] : rd_word[7:0]}; // [RULE_09]
  assign rdata_nxt = host_rd_i ? lane_word : rdata_r;

  // ************************************************
  // Flops
  // ************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      bank_r <= BANK_RST; // [RULE_12]
      tx_r <= TX_CTRL_RST; // [RULE_12]
      cfg_opt_r <= CFG_OPT_RST;
      cfg_sts_r <= CFG_STS_RST;
    end
    else
    begin
      bank_r <= bank_nxt;
      tx_r <= tx_nxt;
      cfg_opt_r <= cfg_opt_nxt;
      cfg_sts_r <= cfg_sts_nxt;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= host_rd_i;
    end
  end

  // ************************************************
  // Transmit control effects
  // ************************************************
  logic sw_fdx;

  assign sw_fdx = tx_r[TC_SW_FDX];
  assign fcs_append_o = ~tx_r[TC_FCS_SUP]; // [RULE_13]
  // Transmit and receive decouple: no deferral, no collision sense
  assign csma_enable_o = ~sw_fdx; // [RULE_14]
  assign full_duplex_accept_o = sw_fdx | tx_r[TC_FD_ACC]; // [RULE_15]
  assign carrier_monitor_o = ~sw_fdx & tx_r[TC_CAR_MON]; // [RULE_15]
  // Serial loop before the encoder; datapath must restart after it
  assign phy_loopback_o = tx_r[TC_PHY_LOOP]; // [RULE_18] [RULE_19]
  assign encdec_loopback_o = tx_r[TC_LOOP];
  assign tx_enable_o = tx_r[TC_TXENA];
  assign pad_enable_o = tx_r[TC_PAD_EN];
  assign force_collision_o = tx_r[TC_FORCOL];
  assign stop_on_sqe_o = tx_r[TC_STP_SQE];
  assign bank_o = bank_r;
  assign power_down_o = pwr_down;
  assign int_ready_o = ~soft_hold; // [RULE_20]
  assign attr_write_en_o = cfg_opt_r[CO_WR_ATTR];
  assign host_rdata_o = rdata_r;
  assign host_rvalid_o = rvalid_r;

  bio_underrun_cmp u_underrun
  (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .early_tx_enable_i(early_tx_enable_i),
    .compare_type_i(tx_r[TC_ET_TYPE]), // [RULE_16] [RULE_17]
    .dma_tx_addr_i(dma_tx_addr_i),
    .load_addr_i(load_addr_i),
    .tx_pkt_num_i(tx_pkt_num_i),
    .load_pkt_num_i(load_pkt_num_i),
    .force_underrun_o(force_underrun_o)
  );

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);

  sequence s_bsel_read;
    host_rd_i && hit_bsel && !blocked;
  endsequence

  sequence s_soft_reset;
    srst_set ##1 soft_hold;
  endsequence

  a_reset_defaults: assert property ($fell(srst_i) // [RULE_12]
    |-> bank_r == BANK_RST && tx_r == TX_CTRL_RST)
    else $error("registers not at reset value");

  a_sig_upper: assert property (s_bsel_read and word_acc // [RULE_07]
    |=> host_rvalid_o && host_rdata_o[15:8] == SIG_BYTE
        && host_rdata_o[2:0] == $past(bank_r))
    else $error("bank word read wrong");

  a_sig_odd_byte: assert property (s_bsel_read and hi_sel // [RULE_07]
    |=> host_rdata_o == {8'h00, SIG_BYTE})
    else $error("bank upper byte not 33h");

  a_bank_write: assert property (hit_bsel && wr_lo && !srst_set // [RULE_04]
    |=> bank_r == $past(wd_lo[2:0]))
    else $error("bank field write lost");

  a_none_read: assert property (host_rd_i && !bank_exists && !hit_bsel // [RULE_06]
    && !blocked && !word_acc |=> host_rdata_o == {8'h00, NONE_BYTE})
    else $error("nonexistent bank byte read not 33h");

  a_none_write: assert property (host_wr_i && !bank_exists && !hit_bsel // [RULE_06]
    |=> $stable(tx_r) && $stable(cfg_opt_r) && $stable(cfg_sts_r))
    else $error("write to nonexistent bank took effect");

  a_pwrdn_bsel: assert property (power_down_o && host_wr_i && hit_bsel // [RULE_05]
    |=> $stable(bank_r))
    else $error("bank written during power down");

  a_pwrdn_cause: assert property ((cfg_sts_r[CS_PWRDN] // [RULE_21]
    || (pcmcia_mode_i && !cfg_opt_r[CO_FUNC_EN])) |-> power_down_o)
    else $error("power down not entered");

  a_fcs_control: assert property (hit_tx && wr_hi && !soft_hold && !srst_set // [RULE_13]
    |=> fcs_append_o == !$past(wd_hi[TC_FCS_SUP-8]))
    else $error("frame check append wrong");

  a_sw_fdx_force: assert property (tx_r[TC_SW_FDX] // [RULE_14] [RULE_15]
    |-> full_duplex_accept_o && !carrier_monitor_o && !csma_enable_o)
    else $error("switched duplex overrides missing");

  a_phy_loop_set: assert property (hit_tx && wr_hi && !soft_hold && !srst_set // [RULE_18]
    |=> phy_loopback_o == $past(wd_hi[TC_PHY_LOOP-8]))
    else $error("loopback bit not taken");

  a_soft_reset: assert property (s_soft_reset // [RULE_20]
    |-> tx_r == TX_CTRL_RST && cfg_sts_r == CFG_STS_RST
        && bank_r == BANK_RST && !int_ready_o)
    else $error("soft reset did not clear");

  a_reserved_zero: assert property (tx_r[6:4] == 3'h0 && !tx_r[9] // [RULE_22]
    && (cfg_opt_r & ~CFG_OPT_MASK) == 8'h00)
    else $error("undefined bit stored");

  a_byte_lane: assert property (host_rd_i && !word_acc // [RULE_09] [RULE_10]
    |=> host_rdata_o[15:8] == 8'h00)
    else $error("byte read drove upper lane");

  // Held, not just cleared once, while the soft reset bit stays set
  a_soft_hold_tx: assert property (soft_hold // [RULE_20]
    |-> tx_r == TX_CTRL_RST && cfg_sts_r == CFG_STS_RST)
    else $error("function registers not held during soft reset");

  a_pwrdn_read: assert property (host_rd_i && blocked // [RULE_05]
    |=> host_rdata_o == 16'h0000)
    else $error("read answered during power down");

endmodule : bio_window_top

// >>> test/bio_host_model.sv
`timescale 1ns/1ps
module bio_host_model
  import bio_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [DATA_W-1:0] host_rdata_i,
  input wire logic host_rvalid_i,
  output logic [ADDR_W-1:0] host_addr_o,
  output logic host_rd_o,
  output logic host_wr_o,
  output logic host_word_o,
  output logic [DATA_W-1:0] host_wdata_o
);
  initial
  begin
    host_addr_o = 4'h0;
    host_rd_o = 1'b0;
    host_wr_o = 1'b0;
    host_word_o = 1'b0;
    host_wdata_o = 16'h0000;
  end

  // One strobe cycle, answer sampled after the following edge
  task automatic acc(input logic w, input logic [3:0] a, input logic wd,
                     input logic [15:0] d, output logic [15:0] q, output logic v);
    @(posedge sys_clk_i);
    host_addr_o <= a;
    host_word_o <= wd;
    host_wdata_o <= d;
    host_rd_o <= ~w;
    host_wr_o <= w;
    @(posedge sys_clk_i);
    host_rd_o <= 1'b0;
    host_wr_o <= 1'b0;
    // Released bus shows junk, never the last value
    host_addr_o <= ~a;
    host_wdata_o <= ~d;
    #1;
    q = host_rdata_i;
    v = host_rvalid_i;
  endtask : acc
endmodule : bio_host_model

// >>> test/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module testbench
  import bio_pkg::*;
;
  logic clk, srst, rd, wr, word, rvalid, b16, pcm, early_tx_enable;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, q, d;
  logic [10:0] dma, lda;
  logic [5:0] tpn, lpn;
  logic [2:0] bank;
  logic io16, fcs, csma, fda, cmon, phl, urun, pdn, irdy;
  logic encl, txen, pad, fcol, sqe, attr;
  logic [31:0] r;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  bio_window_top dut_u (.sys_clk_i(clk), .srst_i(srst), .host_addr_i(addr),
    .host_rd_i(rd), .host_wr_i(wr), .host_word_i(word), .host_wdata_i(wdata),
    .host_rdata_o(rdata), .host_rvalid_o(rvalid), .host_bus16_i(b16),
    .pcmcia_mode_i(pcm), .early_tx_enable_i(early_tx_enable), .dma_tx_addr_i(dma),
    .load_addr_i(lda), .tx_pkt_num_i(tpn), .load_pkt_num_i(lpn), .bank_o(bank),
    .io_16bit_o(io16), .fcs_append_o(fcs), .csma_enable_o(csma),
    .full_duplex_accept_o(fda), .carrier_monitor_o(cmon), .phy_loopback_o(phl),
    .encdec_loopback_o(encl), .tx_enable_o(txen), .pad_enable_o(pad),
    .force_collision_o(fcol), .stop_on_sqe_o(sqe), .force_underrun_o(urun),
    .power_down_o(pdn), .int_ready_o(irdy), .attr_write_en_o(attr));

  bio_host_model host_u (.sys_clk_i(clk), .host_rdata_i(rdata), .host_rvalid_i(rvalid),
    .host_addr_o(addr), .host_rd_o(rd), .host_wr_o(wr), .host_word_o(word),
    .host_wdata_o(wdata));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ************************************************
  // Helpers
  // ************************************************
  task automatic wa(input logic [3:0] a, input logic wd, input logic [15:0] dd);
    logic [15:0] x;
    logic v;
    host_u.acc(1'b1, a, wd, dd, x, v);
  endtask : wa

  task automatic ra(input logic [3:0] a, input logic wd, input logic [15:0] e);
    logic [15:0] x;
    logic v;
    host_u.acc(1'b0, a, wd, 16'h0000, x, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, x)
  endtask : ra

  function automatic logic exp_ur(logic t, logic en, logic [10:0] da, logic [10:0] la,
                                  logic [5:0] pt, logic [5:0] pl);
    return en && (da > la) && (!t || pt == pl);
  endfunction : exp_ur

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ************************************************
  // Tests
  // ************************************************
  initial
  begin
    srst = 1'b1;
    b16 = 1'b1;
    pcm = 1'b0;
    early_tx_enable = 1'b0;
    dma = 11'h000;
    lda = 11'h000;
    tpn = 6'h00;
    lpn = 6'h00;
    r = $urandom(32'hd92b);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("bank", 3'h0, bank)
    `CHK("fcs", 1'b1, fcs)
    `CHK("csma", 1'b1, csma)
    `CHK("phl", 1'b0, phl)
    `CHK("irdy", 1'b1, irdy)
    `CHK("pdn", 1'b0, pdn)
    `CHK("attr", 1'b0, attr)
    ra(4'he, 1'b1, 16'h3300);
    ra(4'h0, 1'b1, 16'h0000);
    wa(4'he, 1'b1, 16'h0004);
    ra(4'h0, 1'b1, 16'h0040);
    $display("test reset done");
    // Every bank code, junk in the undefined bits
    wa(4'he, 1'b1, 16'h0000);
    wa(4'h0, 1'b1, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      wa(4'he, 1'b1, 16'hfff8 | 16'(i));
      ra(4'he, 1'b1, 16'h3300 | 16'(i));
      ra(4'hf, 1'b0, 16'h0033);
      `CHK("bank", 3'(i), bank)
      if (i > 4)
      begin
        ra(4'h0, 1'b1, 16'h3333);
        ra(4'h1, 1'b0, 16'h0033);
        wa(4'h0, 1'b1, 16'hffff);
      end
    end
    wa(4'he, 1'b1, 16'h0000);
    ra(4'h0, 1'b1, 16'h0000);
    $display("test banks done");
    // Transmit control: random words, then byte lanes
    repeat (12)
    begin
      d = 16'($urandom);
      wa(4'h0, 1'b1, d);
      d = d & TX_CTRL_MASK;
      ra(4'h0, 1'b1, d);
      `CHK("fcs", ~d[8], fcs)
      `CHK("csma", ~d[15], csma)
      `CHK("fda", d[15] | d[11], fda)
      `CHK("cmon", ~d[15] & d[10], cmon)
      `CHK("phl", d[13], phl)
      `CHK("encl", d[1], encl)
      `CHK("txen", d[0], txen)
      `CHK("pad", d[7], pad)
      `CHK("fcol", d[2], fcol)
      `CHK("sqe", d[12], sqe)
    end
    wa(4'h0, 1'b1, 16'h0000);
    wa(4'h1, 1'b0, 16'h00a5);
    ra(4'h0, 1'b1, 16'ha500);
    ra(4'h1, 1'b0, 16'h00a5);
    wa(4'h0, 1'b0, 16'h00ff);
    ra(4'h0, 1'b1, 16'ha58f);
    ra(4'h0, 1'b0, 16'h008f);
    @(posedge clk);
    b16 <= 1'b0;
    ra(4'he, 1'b1, 16'h0000);
    `CHK("io16", 1'b0, io16)
    @(posedge clk);
    b16 <= 1'b1;
    $display("test tcr done");
    // Power down, 8-bit status, PCMCIA enable
    wa(4'he, 1'b1, 16'h0004);
    wa(4'h1, 1'b0, 16'h0004);
    `CHK("pdn", 1'b1, pdn)
    ra(4'he, 1'b1, 16'h0000);
    wa(4'he, 1'b1, 16'h0000);
    `CHK("bank", 3'h4, bank)
    wa(4'h1, 1'b0, 16'h0020);
    `CHK("pdn", 1'b0, pdn)
    `CHK("io16", 1'b0, io16)
    wa(4'h1, 1'b0, 16'h0000);
    @(posedge clk);
    pcm <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("pdn", 1'b1, pdn)
    wa(4'h0, 1'b0, 16'h0005);
    `CHK("pdn", 1'b0, pdn)
    `CHK("attr", 1'b1, attr)
    wa(4'he, 1'b1, 16'h0001);
    ra(4'he, 1'b1, 16'h3301);
    @(posedge clk);
    pcm <= 1'b0;
    $display("test power done");
    // Loopback left via soft reset
    wa(4'he, 1'b1, 16'h0000);
    wa(4'h0, 1'b1, 16'h2001);
    wa(4'he, 1'b1, 16'h0004);
    wa(4'h0, 1'b0, 16'h0081);
    `CHK("irdy", 1'b0, irdy)
    `CHK("bank", 3'h0, bank)
    `CHK("phl", 1'b0, phl)
    `CHK("attr", 1'b0, attr)
    ra(4'h0, 1'b1, 16'h0000);
    wa(4'he, 1'b1, 16'h0004);
    wa(4'h0, 1'b0, 16'h0001);
    `CHK("irdy", 1'b1, irdy)
    wa(4'he, 1'b1, 16'h0000);
    ra(4'h0, 1'b1, 16'h0000);
    $display("test soft reset done");
    // Underrun compare, both types, equal addresses first
    for (int t = 0; t < 2; t++)
    begin
      wa(4'h0, 1'b1, (t == 1) ? 16'h4000 : 16'h0000);
      for (int k = 0; k < 24; k++)
      begin
        @(posedge clk);
        r = $urandom;
        early_tx_enable <= r[0] | (k == 0);
        dma <= r[11:1];
        lda <= (k == 0) ? r[11:1] : r[22:12];
        tpn <= {4'h0, r[24:23]};
        lpn <= {4'h0, r[26:25]};
        @(posedge clk);
        #1;
        `CHK("urun", exp_ur(t[0], early_tx_enable, dma, lda, tpn, lpn), urun)
      end
    end
    $display("test underrun done");
    // Hard reset in mid-run with a bank and control bits set
    wa(4'he, 1'b1, 16'h0003);
    `CHK("bank", 3'h3, bank)
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("bank", 3'h0, bank)
    `CHK("irdy", 1'b1, irdy)
    ra(4'h0, 1'b1, 16'h0000);
    $display("test hard reset done");
    final_report();
  end
endmodule : testbench
